// ---- pmv_top.sv ----
// Program memory organisation, program counter and vector redirection
// Operation
// Requests are taken only in the run state; an interrupt beats a branch, and a branch beats a step.
// An interrupt takes three edges: jump to the entry, read the entry, then jump to its content.
// Requests that arrive during the two vector cycles are dropped, not queued.
// Sources at or above the table size are ignored, so a stray source number cannot reach past a table.
// Image load writes both memories at once, so fetch and half-word reads always see the same image.
// Only the low bits of an address select a location; higher bits alias onto the array.
`timescale 1ns/1ps
module pmv_top (
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic LOAD_EN_I,
    input wire logic [23:0] LOAD_ADDR_I,
    input wire logic [23:0] LOAD_DATA_I,
    input wire logic STEP_I,
    input wire logic STEP_DOWN_I,
    input wire logic BRANCH_I,
    input wire logic [23:0] BRANCH_ADDR_I,
    input wire logic IRQ_I,
    input wire logic [6:0] IRQ_SRC_I,
    input wire logic ALT_TABLE_I,
    input wire logic [23:0] RD_ADDR_I,
    output logic [15:0] RD_DATA_O,
    output logic [23:0] PC_O,
    output logic [23:0] INSTR_O,
    output logic INSTR_VALID_O,
    output logic IRQ_ACK_O,
    output logic IN_VECTOR_SPACE_O
);
    // Location index of a byte-style address: drop the odd/even bit
    function automatic logic [pmv_pkg::MEM_AW-1:0] loc_index(input logic [23:0] a);
        loc_index = a[pmv_pkg::MEM_AW:1];
    endfunction : loc_index

    // Vector entry address for a source in a chosen table
    function automatic logic [23:0] vec_addr(input logic alt, input logic [6:0] src);
        logic [23:0] base;
        base = alt ? pmv_pkg::IVT2_BASE : pmv_pkg::IVT1_BASE;
        vec_addr = base + {16'h0000, src, 1'b0};
    endfunction : vec_addr

    // Clear the odd bit so a target always lands on a lower word
    function automatic logic [23:0] align_pc(input logic [23:0] a);
        align_pc = {a[23:1], 1'b0};
    endfunction : align_pc

    // Sequencer state and registered outputs
    pmv_pkg::pmv_state_t state_ff;
    pmv_pkg::pmv_state_t nxt_state;
    logic [23:0] pc_ff;
    logic [23:0] nxt_pc;
    logic irq_ack_ff;
    logic nxt_irq_ack;
    logic valid_ff;
    logic nxt_valid;
    logic rd_odd_ff;
    logic nxt_rd_odd;

    // Read data of the fetch memory and of the half-word read memory
    logic [23:0] mem_q;
    logic [23:0] dbg_q;
    logic [23:0] word_q;
    logic [pmv_pkg::MEM_AW-1:0] fetch_idx;
    logic [pmv_pkg::MEM_AW-1:0] load_idx;
    logic [pmv_pkg::MEM_AW-1:0] rd_idx;

    // Request decode; only the run state accepts requests
    wire in_run = (state_ff == pmv_pkg::PMV_RUN);
    wire src_ok = (IRQ_SRC_I < pmv_pkg::NUM_SRC);
    wire take_irq = in_run && IRQ_I && src_ok;
    wire take_branch = in_run && !take_irq && BRANCH_I;
    wire take_step = in_run && !take_irq && !BRANCH_I && STEP_I;

    // Candidate program counter values
    wire [23:0] irq_vec = vec_addr(ALT_TABLE_I, IRQ_SRC_I);
    wire [23:0] branch_pc = align_pc(BRANCH_ADDR_I);
    wire [23:0] up_pc = pc_ff + pmv_pkg::PC_STEP;
    wire [23:0] down_pc = pc_ff - pmv_pkg::PC_STEP;
    wire [23:0] step_pc = STEP_DOWN_I ? down_pc : up_pc;
    wire [23:0] jump_pc = align_pc(mem_q);

    // Fetch reads where the counter goes next, so the word changes on the same edge as the counter
    assign fetch_idx = loc_index(nxt_pc);
    assign load_idx = loc_index(LOAD_ADDR_I);
    assign rd_idx = loc_index(RD_ADDR_I);
    assign word_q = mem_q; // Only 24 bits exist per location
    assign nxt_rd_odd = RD_ADDR_I[0];

    // Fetch memory; also supplies the vector entry during redirection
    pmv_mem u_mem (
        .clk_i(REF_CLK_I),
        .wr_en_i(LOAD_EN_I),
        .wr_addr_i(load_idx),
        .wr_data_i(LOAD_DATA_I),
        .rd_addr_i(fetch_idx),
        .rd_data_o(mem_q)
    );

    // Second copy of the image so half-word reads never stall the fetch
    pmv_mem u_dbg_mem (
        .clk_i(REF_CLK_I),
        .wr_en_i(LOAD_EN_I),
        .wr_addr_i(load_idx),
        .wr_data_i(LOAD_DATA_I),
        .rd_addr_i(rd_idx),
        .rd_data_o(dbg_q)
    );

    // Next state and program counter of the redirection sequence
    always_comb begin
        nxt_state = state_ff;
        nxt_pc = pc_ff;
        nxt_irq_ack = 1'b0;
        nxt_valid = 1'b0;
        unique case (state_ff)
            pmv_pkg::PMV_RUN: begin
                nxt_valid = !take_irq;
                if (take_irq) begin
                    nxt_pc = irq_vec;
                    nxt_irq_ack = 1'b1;
                    nxt_state = pmv_pkg::PMV_VEC_FETCH;
                end else if (take_branch) begin
                    nxt_pc = branch_pc;
                end else if (take_step) begin
                    nxt_pc = step_pc;
                end
            end
            pmv_pkg::PMV_VEC_FETCH: begin
                nxt_state = pmv_pkg::PMV_VEC_JUMP; // Entry read in flight
            end
            pmv_pkg::PMV_VEC_JUMP: begin
                nxt_pc = jump_pc;
                nxt_state = pmv_pkg::PMV_RUN;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            state_ff <= pmv_pkg::PMV_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Program counter; reset lands on the reset vector
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            pc_ff <= pmv_pkg::RESET_VEC;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    // One-cycle acknowledge of a taken interrupt
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            irq_ack_ff <= 1'b0;
        end else begin
            irq_ack_ff <= nxt_irq_ack;
        end
    end

    // Fetched word valid flag
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= nxt_valid;
        end
    end

    // Odd/even bit of the half-word read, aligned with the registered read data
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            rd_odd_ff <= 1'b0;
        end else begin
            rd_odd_ff <= nxt_rd_odd;
        end
    end

    // Half-word read: even gives the lower word, odd the upper word with a zero top byte
    assign RD_DATA_O = rd_odd_ff ? {pmv_pkg::UPPER_PAD, dbg_q[23:16]} : dbg_q[15:0];

    // Outputs; fetched word is the location at the program counter
    assign PC_O = pc_ff;
    assign INSTR_O = word_q;
    assign INSTR_VALID_O = valid_ff;
    assign IRQ_ACK_O = irq_ack_ff;
    assign IN_VECTOR_SPACE_O = (pc_ff < pmv_pkg::VEC_END);
endmodule : pmv_top

// ---- pmv_pkg.sv ----
// Package with constants for the program memory vector map block
package pmv_pkg;
    localparam int ADDR_W = 24;
    localparam int WORD_W = 24;
    localparam int HALF_W = 16;
    localparam int MEM_AW = 10;
    localparam logic [23:0] RESET_VEC = 24'h000000;
    localparam logic [23:0] START_PTR_ADDR = 24'h000002;
    localparam logic [23:0] IVT1_BASE = 24'h000004;
    localparam logic [23:0] IVT1_LAST = 24'h0000FF;
    localparam logic [23:0] IVT2_BASE = 24'h000100;
    localparam logic [23:0] IVT2_LAST = 24'h0001FF;
    localparam logic [23:0] VEC_END = 24'h000200;
    localparam logic [23:0] PC_STEP = 24'h000002;
    localparam logic [7:0] UPPER_PAD = 8'h00;
    localparam logic [6:0] NUM_SRC = 7'h7E;
    typedef enum logic [1:0] {PMV_RUN, PMV_VEC_FETCH, PMV_VEC_JUMP} pmv_state_t;
endpackage : pmv_pkg

// ---- pmv_mem.sv ----
// Program memory array of 24-bit locations with registered read data
`timescale 1ns/1ps
module pmv_mem (
    input wire logic clk_i,
    input wire logic wr_en_i,
    input wire logic [pmv_pkg::MEM_AW-1:0] wr_addr_i,
    input wire logic [pmv_pkg::WORD_W-1:0] wr_data_i,
    input wire logic [pmv_pkg::MEM_AW-1:0] rd_addr_i,
    output logic [pmv_pkg::WORD_W-1:0] rd_data_o
);
    logic [pmv_pkg::WORD_W-1:0] mem [0:(1<<pmv_pkg::MEM_AW)-1];

    // Write port and registered read port
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule : pmv_mem

// ---- pmv_core_mdl.sv ----
// Core fetch model that requests program counter steps
`timescale 1ns/1ps
module pmv_core_mdl (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic [7:0] rnd_i,
    output logic step_o = 1'b0,
    output logic down_o = 1'b0
);
    // Random stalls give back to back steps as well as gaps
    always @(posedge clk_i) begin
        step_o <= en_i && rnd_i[0];
        down_o <= rnd_i[1];
    end
endmodule : pmv_core_mdl

// ---- pmv_chk.sv ----
// Checker for the program counter, vector and read ports
`timescale 1ns/1ps
module pmv_chk (
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic STEP_I,
    input wire logic STEP_DOWN_I,
    input wire logic BRANCH_I,
    input wire logic [23:0] BRANCH_ADDR_I,
    input wire logic IRQ_I,
    input wire logic [6:0] IRQ_SRC_I,
    input wire logic ALT_TABLE_I,
    input wire logic [23:0] RD_ADDR_I,
    input wire logic [15:0] RD_DATA_O,
    input wire logic [23:0] PC_O,
    input wire logic INSTR_VALID_O,
    input wire logic IRQ_ACK_O,
    input wire logic IN_VECTOR_SPACE_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);
    // Run state with no higher priority request
    wire run = INSTR_VALID_O && !IRQ_I && !BRANCH_I;
    pc_even_a: assert property (PC_O[0] == 1'b0) else $error("odd pc");
    pc_step_a: assert property (run && STEP_I |=>
        PC_O == $past(PC_O) + ($past(STEP_DOWN_I) ? 24'hFFFFFE : 24'h000002)) else $error("bad step");
    reset_pc_a: assert property (disable iff (1'b0) RESET_I |=> PC_O == 24'h000000 && !IRQ_ACK_O)
        else $error("bad reset pc");
    irq_entry_a: assert property (INSTR_VALID_O && IRQ_I && IRQ_SRC_I < 7'h7E |=> IRQ_ACK_O &&
        PC_O == ($past(ALT_TABLE_I) ? 24'h000100 : 24'h000004) + {$past(IRQ_SRC_I), 1'b0}) else $error("bad entry");
    irq_refuse_a: assert property (INSTR_VALID_O && IRQ_I && IRQ_SRC_I >= 7'h7E && !BRANCH_I && !STEP_I
        |=> !IRQ_ACK_O && $stable(PC_O)) else $error("bad source taken");
    upper_zero_a: assert property (RD_ADDR_I[0] |=> RD_DATA_O[15:8] == 8'h00) else $error("upper byte");
    vec_space_a: assert property (IN_VECTOR_SPACE_O == (PC_O < 24'h000200)) else $error("vector flag");
    branch_pc_a: assert property (INSTR_VALID_O && BRANCH_I && !IRQ_I |=>
        PC_O == ($past(BRANCH_ADDR_I) & 24'hFFFFFE)) else $error("bad branch");
    cover property (IRQ_ACK_O && ALT_TABLE_I);
    cover property (run && STEP_I && STEP_DOWN_I);
    cover property (RD_ADDR_I[0]);
endmodule : pmv_chk
bind pmv_top pmv_chk u_pmv_chk (.*);

// ---- tb_top.sv ----
// Testbench for image load, reads, steps, branches and interrupts
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst = 1, ld = 0, br = 0, irq = 0, alt = 0, en = 0, step, down, ack, iv, ivs;
    logic [23:0] la = 0, ldd = 0, ba = 0, ra = 0, pc, ins;
    logic [15:0] rd;
    logic [6:0] src = 0;
    logic [7:0] rnd = 8'h4D;
    logic [15:0] q[$];
    int bad_count = 0, cmp_count = 0;
    always #10 clk = ~clk;
    pmv_top u_pmv_top (.REF_CLK_I(clk), .RESET_I(rst), .LOAD_EN_I(ld), .LOAD_ADDR_I(la), .LOAD_DATA_I(ldd),
        .STEP_I(step), .STEP_DOWN_I(down), .BRANCH_I(br), .BRANCH_ADDR_I(ba), .IRQ_I(irq), .IRQ_SRC_I(src),
        .ALT_TABLE_I(alt), .RD_ADDR_I(ra), .RD_DATA_O(rd), .PC_O(pc), .INSTR_O(ins), .INSTR_VALID_O(iv),
        .IRQ_ACK_O(ack), .IN_VECTOR_SPACE_O(ivs));
    pmv_core_mdl u_pmv_core_mdl (.clk_i(clk), .en_i(en), .rnd_i(rnd), .step_o(step), .down_o(down));
    function automatic logic [7:0] lf(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lf
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [23:0] a, input logic [23:0] d);
        @(posedge clk); ld <= 1'b1; la <= a; ldd <= d;
        @(posedge clk); ld <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [23:0] a, input logic [15:0] e);
        @(posedge clk); ra <= a;
        @(posedge clk); q.push_back(e);
    endtask : rd_chk
    task automatic irq_go(input logic a, input logic [6:0] s, input logic [23:0] ent, isr, input logic k);
        for (int i = 0; iv !== 1'b1; i++) begin
            if (i > 9) begin
                bad_count++;
                complete_run();
            end else @(posedge clk);
        end
        @(posedge clk); irq <= 1'b1; alt <= a; src <= s;
        @(posedge clk); irq <= 1'b0;
        #1 chk(pc, ent);
        chk({23'h000000, ack}, {23'h000000, k});
        repeat (2) @(posedge clk);
        #1 chk(pc, isr);
    endtask : irq_go
    // Read results are matched against the oldest note
    always @(negedge clk) if (q.size() > 0) chk({8'h00, rd}, {8'h00, q.pop_front()});
    initial begin
        logic [23:0] d, first;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1 chk(pc, 24'h000000);
        wr(24'h000000, 24'h040000);
        wr(24'h000002, 24'h000400);
        wr(24'h00000A, 24'h000600);
        wr(24'h000106, 24'h000700);
        for (int k = 0; k < 4; k++) begin
            d = {rnd, rnd ^ 8'hA5, ~rnd};
            if (k == 0) first = d;
            wr(24'h000400 + 24'(2 * k), d);
            rd_chk(24'h000400 + 24'(2 * k), d[15:0]);
            rd_chk(24'h000401 + 24'(2 * k), {8'h00, d[23:16]});
            rnd <= lf(rnd);
        end
        en <= 1'b1;
        repeat (20) begin @(posedge clk); rnd <= lf(rnd); end
        en <= 1'b0;
        repeat (2) @(posedge clk);
        br <= 1'b1; ba <= 24'h000401;
        @(posedge clk); br <= 1'b0;
        #1 chk(pc, 24'h000400);
        chk({23'h000000, ivs}, 24'h000000);
        @(posedge clk); #1 chk(ins, first);
        irq_go(1'b0, 7'h03, 24'h00000A, 24'h000600, 1'b1);
        irq_go(1'b1, 7'h03, 24'h000106, 24'h000700, 1'b1);
        irq_go(1'b0, 7'h7E, 24'h000700, 24'h000700, 1'b0);
        complete_run();
    end
endmodule : tb_top
